/* src/clock_divider_setup_decoder.v */
// setup strap decoder driving three phase dividers, with an AXI4-Lite status port
// assumes straps and sync pin are synchronous to aclk, which stands for the input clock
`timescale 1ns/1ps
`include "clock_divider_setup_decoder_defines.vh"

// Operation
// R1 - four levels; floating pin reads one third
// R2 - fine word: delay fraction, else phase two
// R3 - usage select picks which outputs run
// R4 - fine step is index sixteenths of scale
// R5 - field A: ratio two, else phase one
// R6 - field B: ratio one, else phase two; the code drops field B as phase two when range select is bypass
// R7 - field C: ratio zero, else ratio two
// R8 - range select: bypass, 1.8, 6.0, 11.6 ns
// R9 - format table by usage and format level
// R10 - index low plus four times high; ratio list
// R11 - even ratios 50%, odd high floor half
// R12 - field B shares field A encoding
// R13 - fine index formed like other fields
// R14 - field C alternate ratio list for output two
// R15 - wait phase cycles after sync; wraps
// R16 - hold during sync, resume four cycles later
// R17 - combinational re-decode of level codes
// R18 - ratio one bypasses phase and sync
module clock_divider_setup_decoder #(
	parameter ADDR_W  = 8,
	parameter RATIO_W = 6
) (
	// clock and reset
	input  wire              aclk,
	input  wire              aresetn,
	// setup straps, two-bit level codes, then one float flag per strap
	input  wire [1:0]        delay_range_select,
	input  wire [1:0]        output_format_select,
	input  wire [1:0]        output_usage_select,
	input  wire [1:0]        fine_word_low,
	input  wire [1:0]        fine_word_high,
	input  wire [1:0]        shared_field_a_low,
	input  wire [1:0]        shared_field_a_high,
	input  wire [1:0]        shared_field_b_low,
	input  wire [1:0]        shared_field_b_high,
	input  wire [1:0]        shared_field_c_low,
	input  wire [1:0]        shared_field_c_high,
	input  wire [10:0]       setup_float,
	// sync pin
	input  wire              sync_request_n,
	// clock outputs and their settings
	output wire              clock_output_zero,
	output wire              clock_output_one,
	output wire              clock_output_two,
	output reg  [1:0]        format_zero_reg,
	output reg  [1:0]        format_one_reg,
	output reg  [1:0]        format_two_reg,
	output reg  [13:0]       delay_full_scale_ps_reg,
	output reg  [3:0]        delay_fraction_reg,
	// AXI4-Lite write
	input  wire [ADDR_W-1:0] awaddr,
	input  wire              awvalid,
	output reg               awready,
	input  wire [31:0]       wdata,
	input  wire [3:0]        wstrb,
	input  wire              wvalid,
	output reg               wready,
	output reg  [1:0]        bresp,
	output reg               bvalid,
	input  wire              bready,
	// AXI4-Lite read
	input  wire [ADDR_W-1:0] araddr,
	input  wire              arvalid,
	output reg               arready,
	output reg  [31:0]       rdata,
	output reg  [1:0]        rresp,
	output reg               rvalid,
	input  wire              rready
);
	// effective levels after the float override
	reg  [1:0]         lvl [0:10];
	reg  [3:0]         fine_idx;
	reg  [3:0]         a_idx;
	reg  [3:0]         b_idx;
	reg  [3:0]         c_idx;
	reg  [5:0]         fmt_bits;
	reg  [RATIO_W-1:0] ratio0_next;
	reg  [RATIO_W-1:0] ratio1_next;
	reg  [RATIO_W-1:0] ratio2_next;
	reg  [3:0]         phase1_next;
	reg  [3:0]         phase2_next;
	reg  [3:0]         fraction_next;
	reg  [13:0]        full_scale_next;
	reg                sw_sync_reg;
	reg  [ADDR_W-1:0]  aw_addr_reg;
	reg  [31:0]        w_data_reg;
	reg  [3:0]         w_strb_reg;
	reg                aw_got_reg;
	reg                w_got_reg;
	reg  [31:0]        read_word;
	reg                read_hit;
	wire               sync_active;
	integer            i;

	// standard ratio list
	function [RATIO_W-1:0] std_ratio;
		input [3:0] idx;
		begin
			case (idx) // [R10] [R12]
				4'h0: std_ratio = 6'h01;
				4'h1: std_ratio = 6'h02;
				4'h2: std_ratio = 6'h03;
				4'h3: std_ratio = 6'h04;
				4'h4: std_ratio = 6'h05;
				4'h5: std_ratio = 6'h06;
				4'h6: std_ratio = 6'h08;
				4'h7: std_ratio = 6'h09;
				4'h8: std_ratio = 6'h0A;
				4'h9: std_ratio = 6'h0C;
				4'hA: std_ratio = 6'h0F;
				4'hB: std_ratio = 6'h10;
				4'hC: std_ratio = 6'h12;
				4'hD: std_ratio = 6'h18;
				4'hE: std_ratio = 6'h1E;
				default: std_ratio = 6'h20;
			endcase
		end
	endfunction

	// alternate list when field C drives output two
	function [RATIO_W-1:0] alt_ratio;
		input [3:0] idx;
		begin
			case (idx) // [R14]
				4'h0: alt_ratio = 6'h07;
				4'h1: alt_ratio = 6'h0B;
				4'h2: alt_ratio = 6'h0D;
				4'h3: alt_ratio = 6'h0E;
				4'h4: alt_ratio = 6'h11;
				4'h5: alt_ratio = 6'h13;
				4'h6: alt_ratio = 6'h14;
				4'h7: alt_ratio = 6'h15;
				4'h8: alt_ratio = 6'h16;
				4'h9: alt_ratio = 6'h17;
				4'hA: alt_ratio = 6'h19;
				4'hB: alt_ratio = 6'h1A;
				4'hC: alt_ratio = 6'h1B;
				4'hD: alt_ratio = 6'h1C;
				4'hE: alt_ratio = 6'h1D;
				default: alt_ratio = 6'h1F;
			endcase
		end
	endfunction

	// whole configuration is rebuilt on any level change
	always @* begin // [R17]
		lvl[0]  = delay_range_select;
		lvl[1]  = output_format_select;
		lvl[2]  = output_usage_select;
		lvl[3]  = fine_word_low;
		lvl[4]  = fine_word_high;
		lvl[5]  = shared_field_a_low;
		lvl[6]  = shared_field_a_high;
		lvl[7]  = shared_field_b_low;
		lvl[8]  = shared_field_b_high;
		lvl[9]  = shared_field_c_low;
		lvl[10] = shared_field_c_high;
		for (i = 0; i < 11; i = i + 1) begin
			if (setup_float[i])
				lvl[i] = `LEVEL_THIRD; // [R1]
		end
		fine_idx = {lvl[4], lvl[3]}; // [R13]
		a_idx    = {lvl[6], lvl[5]}; // [R10]
		b_idx    = {lvl[8], lvl[7]}; // [R12]
		c_idx    = {lvl[10], lvl[9]}; // [R10]

		// packed as {two, one, zero}
		case ({lvl[2], lvl[1]}) // [R9] [R3]
			4'h0: fmt_bits = 6'h04;
			4'h1: fmt_bits = 6'h0A;
			4'h2: fmt_bits = 6'h05;
			4'h3: fmt_bits = 6'h09;
			4'h4: fmt_bits = 6'h2A;
			4'h5: fmt_bits = 6'h15;
			4'h6: fmt_bits = 6'h25;
			4'h7: fmt_bits = 6'h1A;
			4'h8: fmt_bits = 6'h00;
			4'h9: fmt_bits = 6'h10;
			4'hA: fmt_bits = 6'h20;
			4'hB: fmt_bits = 6'h08;
			4'hC: fmt_bits = 6'h21;
			4'hD: fmt_bits = 6'h12;
			4'hE: fmt_bits = 6'h11;
			default: fmt_bits = 6'h22;
		endcase

		// unused ratios default to bypass; their outputs are off anyway
		ratio0_next = 6'h01;
		ratio1_next = 6'h01;
		ratio2_next = 6'h01;
		phase1_next = 4'h0;
		phase2_next = 4'h0;
		if (lvl[2] != `LEVEL_ZERO)
			ratio2_next = std_ratio(a_idx); // [R5]
		else
			phase1_next = a_idx; // [R5]
		if (lvl[2] != `LEVEL_ONE)
			ratio1_next = std_ratio(b_idx); // [R6]
		else if (lvl[0] != `LEVEL_ZERO)
			phase2_next = b_idx; // [R6] [R12]
		if (lvl[2] != `LEVEL_TWO_THIRDS)
			ratio0_next = std_ratio(c_idx); // [R7]
		else
			ratio2_next = alt_ratio(c_idx); // [R7] [R14]
		if (lvl[0] == `LEVEL_ZERO)
			phase2_next = fine_idx; // [R2]

		// fraction in sixteenths, so fifteen sixteenths at most
		fraction_next = (lvl[0] != `LEVEL_ZERO) ? fine_idx : 4'h0; // [R2] [R4]
		case (lvl[0]) // [R8]
			`LEVEL_THIRD:      full_scale_next = `DELAY_FS_SHORT_PS;
			`LEVEL_TWO_THIRDS: full_scale_next = `DELAY_FS_MID_PS;
			`LEVEL_ONE:        full_scale_next = `DELAY_FS_LONG_PS;
			default:           full_scale_next = `DELAY_FS_NONE_PS;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			format_zero_reg         <= `FORMAT_OFF;
			format_one_reg          <= `FORMAT_OFF;
			format_two_reg          <= `FORMAT_OFF;
			delay_full_scale_ps_reg <= `DELAY_FS_NONE_PS;
			delay_fraction_reg      <= 4'h0;
		end else begin
			format_zero_reg         <= fmt_bits[1:0];
			format_one_reg          <= fmt_bits[3:2];
			format_two_reg          <= fmt_bits[5:4];
			delay_full_scale_ps_reg <= full_scale_next;
			delay_fraction_reg      <= fraction_next; // [R4]
		end
	end

	// software hold ors with the pin so either can resync
	assign sync_active = ~sync_request_n | sw_sync_reg; // [R16]

	phase_divider #(.RATIO_W(RATIO_W)) divider_zero (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ratio   (ratio0_next), // [R11] [R18]
		.phase   (4'h0),
		.enable  (fmt_bits[1:0] != `FORMAT_OFF),
		.hold    (sync_active),
		.clk_out (clock_output_zero)
	);

	phase_divider #(.RATIO_W(RATIO_W)) divider_one (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ratio   (ratio1_next),
		.phase   (phase1_next), // [R15]
		.enable  (fmt_bits[3:2] != `FORMAT_OFF),
		.hold    (sync_active),
		.clk_out (clock_output_one)
	);

	phase_divider #(.RATIO_W(RATIO_W)) divider_two (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ratio   (ratio2_next),
		.phase   (phase2_next),
		.enable  (fmt_bits[5:4] != `FORMAT_OFF),
		.hold    (sync_active),
		.clk_out (clock_output_two)
	);

	// read decode
	always @* begin
		read_hit  = 1'b1;
		read_word = 32'h00000000;
		case (araddr)
			`REG_CONTROL_OFFSET: read_word[`CONTROL_SYNC_BIT] = sw_sync_reg;
			`REG_RATIOS_OFFSET:  read_word = {10'h000, ratio2_next, 2'h0, ratio1_next, 2'h0, ratio0_next};
			`REG_PHASE_OFFSET:   read_word = {6'h00, lvl[0], 4'h0, fraction_next, 4'h0, phase2_next,
				4'h0, phase1_next};
			`REG_FORMAT_OFFSET: begin
				read_word[5:0]              = fmt_bits;
				read_word[`STATUS_SYNC_BIT] = sync_active;
			end
			default: read_hit = 1'b0;
		endcase
	end

	// write side: address and data taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready     <= 1'b1;
			wready      <= 1'b1;
			bvalid      <= 1'b0;
			bresp       <= `RESP_OKAY;
			aw_got_reg  <= 1'b0;
			w_got_reg   <= 1'b0;
			aw_addr_reg <= {ADDR_W{1'b0}};
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			sw_sync_reg <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_addr_reg <= awaddr;
				aw_got_reg  <= 1'b1;
				awready     <= 1'b0;
			end
			if (wvalid && wready) begin
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
				w_got_reg  <= 1'b1;
				wready     <= 1'b0;
			end
			if (aw_got_reg && w_got_reg && !bvalid) begin
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
				bvalid     <= 1'b1;
				if (aw_addr_reg == `REG_CONTROL_OFFSET) begin
					bresp <= `RESP_OKAY;
					if (w_strb_reg[0])
						sw_sync_reg <= w_data_reg[`CONTROL_SYNC_BIT];
				end else if (aw_addr_reg == `REG_RATIOS_OFFSET || aw_addr_reg == `REG_PHASE_OFFSET ||
					aw_addr_reg == `REG_FORMAT_OFFSET) begin
					// status words ignore writes
					bresp <= `RESP_OKAY;
				end else begin
					bresp <= `RESP_SLVERR;
				end
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// read side
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= read_word;
			rresp   <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end
endmodule // clock_divider_setup_decoder

/* src/clock_divider_setup_decoder_defines.vh */
// constants for the setup decoder and its dividers
// assumes setup levels arrive as two-bit codes 0..3
`ifndef CLOCK_DIVIDER_SETUP_DECODER_DEFINES_VH
`define CLOCK_DIVIDER_SETUP_DECODER_DEFINES_VH

// level codes
`define LEVEL_ZERO       2'h0
`define LEVEL_THIRD      2'h1
`define LEVEL_TWO_THIRDS 2'h2
`define LEVEL_ONE        2'h3

// output format codes
`define FORMAT_OFF  2'h0
`define FORMAT_LVDS 2'h1
`define FORMAT_CMOS 2'h2

// delay full scale in picoseconds
`define DELAY_FS_NONE_PS  14'h0000
`define DELAY_FS_SHORT_PS 14'h0708
`define DELAY_FS_MID_PS   14'h1770
`define DELAY_FS_LONG_PS  14'h2D50

// input clock cycles from sync release to resume
`define SYNC_RESUME_CYCLES 6'h04

// register byte offsets
`define REG_CONTROL_OFFSET 8'h00
`define REG_RATIOS_OFFSET  8'h04
`define REG_PHASE_OFFSET   8'h08
`define REG_FORMAT_OFFSET  8'h0C

// field positions
`define CONTROL_SYNC_BIT 0
`define STATUS_SYNC_BIT  16

// bus responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

/* src/phase_divider.v */
// one output divider with phase offset and sync hold
// assumes ratio is never zero and aclk is the input clock
`timescale 1ns/1ps
module phase_divider #(
	parameter RATIO_W = 6
) (
	// clock and reset
	input  wire               aclk,
	input  wire               aresetn,
	// settings
	input  wire [RATIO_W-1:0] ratio,
	input  wire [3:0]         phase,
	input  wire               enable,
	input  wire               hold,
	// output
	output reg                clk_out
);
	reg  [RATIO_W-1:0] count_reg;
	reg  [RATIO_W-1:0] wait_reg;
	reg                primed_reg;
	wire [RATIO_W-1:0] phase_wide;
	wire [RATIO_W-1:0] phase_eff;
	wire [RATIO_W-1:0] wait_load;
	wire [RATIO_W-1:0] high_time;

	assign phase_wide = {{(RATIO_W-4){1'b0}}, phase};
	// an offset at or past the ratio wraps to the same phase
	assign phase_eff  = (phase_wide >= ratio) ? (phase_wide % ratio) : phase_wide; // [R15]
	assign wait_load  = `SYNC_RESUME_CYCLES + phase_eff; // [R16] [R15]
	// odd ratios keep the shorter half high
	assign high_time  = ratio >> 1; // [R11]

	always @(posedge aclk) begin
		if (!aresetn) begin
			count_reg  <= {RATIO_W{1'b0}};
			wait_reg   <= {RATIO_W{1'b0}};
			primed_reg <= 1'b0;
			clk_out    <= 1'b0;
		end else if (!enable) begin
			count_reg  <= {RATIO_W{1'b0}};
			primed_reg <= 1'b0;
			clk_out    <= 1'b0;
		end else if (ratio == {{(RATIO_W-1){1'b0}}, 1'b1}) begin
			// bypass: a register cannot toggle at the full rate, so it stands high
			count_reg  <= {RATIO_W{1'b0}};
			primed_reg <= 1'b0;
			clk_out    <= 1'b1; // [R18]
		end else if (hold || !primed_reg) begin
			count_reg  <= {RATIO_W{1'b0}};
			wait_reg   <= wait_load; // [R16]
			primed_reg <= 1'b1;
			clk_out    <= 1'b0; // [R16]
		end else if (wait_reg != {RATIO_W{1'b0}}) begin
			wait_reg <= wait_reg - {{(RATIO_W-1){1'b0}}, 1'b1}; // [R15]
			clk_out  <= 1'b0;
		end else begin
			clk_out <= (count_reg < high_time) ? 1'b1 : 1'b0; // [R11]
			if (count_reg == ratio - {{(RATIO_W-1){1'b0}}, 1'b1})
				count_reg <= {RATIO_W{1'b0}};
			else
				count_reg <= count_reg + {{(RATIO_W-1){1'b0}}, 1'b1};
		end
	end
endmodule // phase_divider

/* tb/strap_board.sv */
// board strap model: level codes on the setup pins, open pins left floating
// assumes the bench supplies wanted levels, pin i at bits [2i+1:2i]
`timescale 1ns/1ps
module strap_board (
	// wanted levels and open pins
	input  logic [21:0] want,
	input  logic [10:0] open_mask,
	// toward the decoder
	output logic [21:0] pins,
	output logic [10:0] setup_float
);
	// an open pin shows the inverse code, so only the bias level may count
	always_comb begin
		setup_float = open_mask;
		for (int i = 0; i < 11; i++)
			pins[2*i +: 2] = open_mask[i] ? ~want[2*i +: 2] : want[2*i +: 2];
	end
endmodule // strap_board

/* tb/setup_decoder_monitor.sv */
// checker for strap decode, sync hold and bus handshakes
// assumes one clock aclk and a synchronous active-low reset
`timescale 1ns/1ps
module setup_decoder_monitor (
	// clock and reset
	input logic        aclk,
	input logic        aresetn,
	// straps and sync
	input logic [1:0]  delay_range_select,
	input logic [1:0]  output_usage_select,
	input logic [10:0] setup_float,
	input logic        sync_request_n,
	// outputs
	input logic        clock_output_zero,
	input logic        clock_output_one,
	input logic        clock_output_two,
	input logic [1:0]  format_zero_reg,
	input logic [1:0]  format_one_reg,
	input logic [1:0]  format_two_reg,
	input logic [13:0] delay_full_scale_ps_reg,
	input logic [3:0]  delay_fraction_reg,
	// bus
	input logic [1:0]  bresp,
	input logic        bvalid,
	input logic        bready,
	input logic        arvalid,
	input logic        arready,
	input logic [31:0] rdata,
	input logic        rvalid,
	input logic        rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [1:0] rng_eff;
	logic [1:0] use_eff;
	assign rng_eff = setup_float[0] ? 2'h1 : delay_range_select;
	assign use_eff = setup_float[2] ? 2'h1 : output_usage_select;
	function automatic logic [13:0] fs_of(input logic [1:0] l);
		fs_of = (l == 2'h1) ? 14'h0708 : (l == 2'h2) ? 14'h1770 : (l == 2'h3) ? 14'h2D50 : 14'h0000;
	endfunction
	sequence sync_held;
		(!sync_request_n)[*3];
	endsequence
	sequence quiet_five;
		(!clock_output_zero)[*5];
	endsequence
	AST_SYNC_HOLD: assert property (sync_held |->
		$stable({clock_output_zero, clock_output_one, clock_output_two}))
		else $error("output moved during sync hold");
	AST_RESUME: assert property ($rose(sync_request_n) && !clock_output_zero |-> quiet_five)
		else $error("output resumed early");
	AST_SCALE: assert property ($past(aresetn) |=> delay_full_scale_ps_reg == fs_of($past(rng_eff)))
		else $error("full scale wrong");
	AST_FRAC_BYPASS: assert property (delay_full_scale_ps_reg == 14'h0000 |-> delay_fraction_reg == 4'h0)
		else $error("fraction set while bypassed");
	AST_USE_OFF2: assert property ($past(aresetn) && use_eff == 2'h0 |=> format_two_reg == 2'h0)
		else $error("output two not off");
	AST_USE_ALL: assert property ($past(aresetn) && use_eff == 2'h1 |=> format_zero_reg != 2'h0
		&& format_one_reg != 2'h0 && format_two_reg != 2'h0)
		else $error("an output off");
	AST_USE_OFF0: assert property ($past(aresetn) && use_eff == 2'h2 |=> format_zero_reg == 2'h0)
		else $error("output zero not off");
	AST_USE_OFF1: assert property ($past(aresetn) && use_eff == 2'h3 |=> format_one_reg == 2'h0)
		else $error("output one not off");
	AST_B_STAND: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	AST_R_STAND: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	AST_AR_BLOCK: assert property (rvalid |-> !arready)
		else $error("read taken while busy");
	AST_R_NEXT: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
endmodule // setup_decoder_monitor

bind clock_divider_setup_decoder setup_decoder_monitor mon (.aclk, .aresetn, .delay_range_select,
	.output_usage_select, .setup_float, .sync_request_n, .clock_output_zero, .clock_output_one, .clock_output_two,
	.format_zero_reg, .format_one_reg, .format_two_reg, .delay_full_scale_ps_reg, .delay_fraction_reg, .bresp,
	.bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready);

/* tb/testbench.sv */
// self-checking bench: strap sweeps, register reads, divider timing after sync
// assumes design, strap board model and monitor compiled before
`timescale 1ns/1ps
module testbench;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        sync_request_n = 1'b1;
	logic [21:0] want = 22'h000000;
	logic [10:0] open_mask = 11'h000;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire  [21:0] pins;
	wire  [10:0] setup_float;
	wire         clock_output_zero, clock_output_one, clock_output_two;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  format_zero_reg, format_one_reg, format_two_reg, bresp, rresp;
	wire  [13:0] delay_full_scale_ps_reg;
	wire  [3:0]  delay_fraction_reg;
	wire  [31:0] rdata;
	int error_cnt = 0, checked = 0;
	int std_r[16] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 15, 16, 18, 24, 30, 32};
	int alt_r[16] = '{7, 11, 13, 14, 17, 19, 20, 21, 22, 23, 25, 26, 27, 28, 29, 31};
	// {two,one,zero} packed: 0 off, 1 lvds, 2 cmos
	int fmt_t[16] = '{4, 10, 5, 9, 42, 21, 37, 26, 0, 16, 32, 8, 33, 18, 17, 34};
	int fs_t[4] = '{0, 1800, 6000, 11600};
	always #12.5 aclk = ~aclk;
	strap_board board (.want, .open_mask, .pins, .setup_float);
	clock_divider_setup_decoder uut (.aclk, .aresetn, .delay_range_select(pins[1:0]),
		.output_format_select(pins[3:2]), .output_usage_select(pins[5:4]), .fine_word_low(pins[7:6]),
		.fine_word_high(pins[9:8]), .shared_field_a_low(pins[11:10]), .shared_field_a_high(pins[13:12]),
		.shared_field_b_low(pins[15:14]), .shared_field_b_high(pins[17:16]), .shared_field_c_low(pins[19:18]),
		.shared_field_c_high(pins[21:20]), .setup_float, .sync_request_n, .clock_output_zero,
		.clock_output_one, .clock_output_two, .format_zero_reg, .format_one_reg, .format_two_reg,
		.delay_full_scale_ps_reg, .delay_fraction_reg, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	function automatic int lvl(int i);
		return open_mask[i] ? 1 : int'(want[2*i +: 2]);
	endfunction
	function automatic int idx(int lo);
		return lvl(lo) + 4 * lvl(lo + 1);
	endfunction
	task automatic end_of_test;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 200) begin
			error_cnt++;
			end_of_test;
		end
	endtask
	// ready is raised a cycle late on purpose, so responses must stand
	task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
		int n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			tick(n);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
			if (bvalid) bready <= 1'b1;
		end
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			tick(n);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
			if (rvalid) rready <= 1'b1;
		end
	endtask
	initial begin
		#125000;
		error_cnt++;
		end_of_test;
	end
	initial begin
		logic [1:0] resp;
		logic [31:0] d;
		logic [12:1] seen0, seen1, seen2;
		int u, r, f, a, b, c, fw, ph2;
		void'($urandom(56259));
		repeat (20) @(posedge aclk);
		chk("reset", 0, {delay_full_scale_ps_reg, delay_fraction_reg, format_two_reg, format_one_reg, format_zero_reg});
		aresetn <= 1'b1;
		repeat (40) begin
			@(posedge aclk);
			want <= 22'($urandom);
			open_mask <= ($urandom % 3 == 0) ? 11'($urandom) : 11'h000;
			repeat (2) @(posedge aclk);
			u = lvl(2); r = lvl(0); f = lvl(1); a = idx(5); b = idx(7); c = idx(9); fw = idx(3);
			chk("formats", fmt_t[u*4+f], {format_two_reg, format_one_reg, format_zero_reg});
			chk("scale", fs_t[r], delay_full_scale_ps_reg);
			chk("fraction", r ? fw : 0, delay_fraction_reg);
			rd(8'h04, d, resp);
			chk("ratios", (u == 2 ? 1 : std_r[c]) + ((u == 3 ? 1 : std_r[b]) << 8)
				+ ((u == 0 ? 1 : u == 2 ? alt_r[c] : std_r[a]) << 16), d);
			ph2 = (u == 3 && r) ? b : (r ? 0 : fw);
			rd(8'h08, d, resp);
			chk("phases", (u ? 0 : a) + (ph2 << 8) + ((r ? fw : 0) << 16) + (r << 24), d);
		end
		wr(8'h00, 32'h00000001, resp);
		rd(8'h0C, d, resp);
		chk("sync_flag", 1, d[16]);
		wr(8'h00, 32'h00000000, resp);
		wr(8'h10, 32'h0000FFFF, resp);
		chk("bad_bresp", 2, resp);
		rd(8'h14, d, resp);
		chk("bad_rresp", 2, resp);
		chk("bad_rdata", 0, d);
		// usage 0: zero at ratio 4, one at ratio 3 with phase 4, two off
		want <= 22'h0C9004;
		open_mask <= 11'h000;
		repeat (3) @(posedge aclk);
		sync_request_n <= 1'b0;
		repeat (4) @(posedge aclk);
		sync_request_n <= 1'b1;
		for (int n = 1; n <= 12; n++) begin
			@(posedge aclk);
			#1;
			seen0[n] = clock_output_zero;
			seen1[n] = clock_output_one;
			seen2[n] = clock_output_two;
		end
		for (int n = 1; n <= 12; n++) begin
			chk("clk_zero", n >= 5 && (n - 5) % 4 < 2, seen0[n]);
			chk("clk_one", n >= 6 && (n - 6) % 3 < 1, seen1[n]);
			chk("clk_two", 0, seen2[n]);
		end
		@(posedge aclk);
		want <= 22'h009004;
		repeat (4) @(posedge aclk);
		sync_request_n <= 1'b0;
		repeat (6) begin
			@(posedge aclk);
			chk("bypass", 1, clock_output_zero);
		end
		sync_request_n <= 1'b1;
		repeat (4) @(posedge aclk);
		end_of_test;
	end
endmodule // testbench
